// >>> hw/adcr_pkg.sv
// adcr_pkg: shared constants for the serial converter readout block
package adcr_pkg;

   // ==========================================================
   // result format
   localparam int          RESULT_W = 16;
   localparam logic [15:0] POS_FS   = 16'h7FFF;
   localparam logic [15:0] NEG_FS   = 16'h8000;
   localparam logic [15:0] SAMPLE_RESET = 16'h0000;

   // ==========================================================
   // falling edge positions within a frame
   localparam int         EDGE_W        = 5;
   localparam logic [4:0] EDGE_NONE     = 5'h00;
   localparam logic [4:0] EDGE_FIRST    = 5'h01;
   localparam logic [4:0] EDGE_ZERO_BIT = 5'h02;
   localparam logic [4:0] EDGE_MSB      = 5'h03;
   localparam logic [4:0] EDGE_ACQ      = 5'h12;

   // ==========================================================
   // timing: the link clock is only sampled, these document margin
   localparam int CLK_PERIOD_NS  = 100;
   localparam int LINK_PERIOD_NS = 800;
   localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

   // ==========================================================
   // frame states
   typedef enum logic [1:0]
   {
      ST_ACQ   = 2'b00,
      ST_ARM   = 2'b01,
      ST_CONV  = 2'b10,
      ST_TRACK = 2'b11
   } adcr_state_t;

endpackage

// >>> hw/adcr_pair_buf.sv
// adcr_pair_buf: small valid/ready buffer with registered flags
`timescale 1ns/1ps
module adcr_pair_buf
   import adcr_pkg::*;
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 2
)
(
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic [WIDTH-1:0]      outData,
   output logic                  outValid,
   input  wire logic             outReady
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0]    wrPtr_reg;
   logic [PW-1:0]    rdPtr_reg;
   logic [CW-1:0]    count_reg;
   logic [CW-1:0]    count_next;
   logic             push;
   logic             pop;

   // ==========================================================
   // handshakes use the registered flags only
   assign push    = inValid && inReady;
   assign pop     = outValid && outReady;
   assign outData = store[rdPtr_reg];

   always_comb
   begin
      count_next = count_reg;
      if (push && !pop)
      begin
         count_next = count_reg + CW'(1);
      end
      else if (pop && !push)
      begin
         count_next = count_reg - CW'(1);
      end
   end

   // storage write, no reset needed on data
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         store[wrPtr_reg] <= inData;
      end
   end

   // pointers and occupancy
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
         inReady   <= 1'b0;
         outValid  <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wrPtr_reg <= (wrPtr_reg == PTR_LAST) ? '0 : wrPtr_reg + PW'(1);
         end
         if (pop)
         begin
            rdPtr_reg <= (rdPtr_reg == PTR_LAST) ? '0 : rdPtr_reg + PW'(1);
         end
         count_reg <= count_next;
         inReady   <= (count_next != CNT_FULL);
         outValid  <= (count_next != '0);
      end
   end

endmodule

// >>> hw/adcr_readout.sv
// adcr_readout: select/clock framing, sample hold and serial result out
`timescale 1ns/1ps
module adcr_readout
   import adcr_pkg::*;
#(
   parameter int IN_W = 18,
   parameter int BUF_DEPTH = 2
)
(
   input  wire logic            ref_clk,
   input  wire logic            reset,
   input  wire logic            chipSelectN,
   input  wire logic            serialClk,
   output logic                 serialDataOut,
   output logic                 serialDataOe,
   input  wire logic [IN_W-1:0] diffIn,
   input  wire logic            diffValid,
   output logic                 diffReady,
   output logic                 conversionMode,
   output logic                 acquisitionMode,
   output logic                 sampleStrobe
);

   // ==========================================================
   // declarations
   localparam logic signed [IN_W-1:0] POS_EXT =
      {{(IN_W-RESULT_W){1'b0}}, POS_FS};
   localparam logic signed [IN_W-1:0] NEG_EXT =
      {{(IN_W-RESULT_W){1'b1}}, NEG_FS};

   logic                csMeta_reg;
   logic                csSync_reg;
   logic                csPrev_reg;
   logic                clkMeta_reg;
   logic                clkSync_reg;
   logic                clkPrev_reg;
   logic                csFall;
   logic                csRise;
   logic                linkFall;
   adcr_state_t         state_reg;
   adcr_state_t         state_next;
   logic [EDGE_W-1:0]   edgeCount_reg;
   logic [EDGE_W-1:0]   edgeCount_next;
   logic [RESULT_W-1:0] sample_reg;
   logic [RESULT_W-1:0] shift_reg;
   logic [IN_W-1:0]     bufData;
   logic                bufValid;
   logic                trackEn;
   logic                bufReadyInt;

   // ==========================================================
   // two-stage synchronisers for both link pins
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         csMeta_reg  <= 1'b1;
         csSync_reg  <= 1'b1;
         csPrev_reg  <= 1'b1;
         clkMeta_reg <= 1'b0;
         clkSync_reg <= 1'b0;
         clkPrev_reg <= 1'b0;
      end
      else
      begin
         csMeta_reg  <= chipSelectN;
         csSync_reg  <= csMeta_reg;
         csPrev_reg  <= csSync_reg;
         clkMeta_reg <= serialClk;
         clkSync_reg <= clkMeta_reg;
         clkPrev_reg <= clkSync_reg;
      end
   end

   // edges seen only past the second stage
   assign csFall   = csPrev_reg && !csSync_reg;
   assign csRise   = !csPrev_reg && csSync_reg;
   assign linkFall = clkPrev_reg && !clkSync_reg;

   // ==========================================================
   // frame state: idle, armed, converting, tracking in frame
   always_comb
   begin
      state_next     = state_reg;
      edgeCount_next = edgeCount_reg;
      if (csSync_reg)
      begin
         // select high aborts any frame and resets the count
         state_next     = ST_ACQ;
         edgeCount_next = EDGE_NONE;
      end
      else
      begin
         unique case (state_reg)
            ST_ACQ:
            begin
               if (csFall && clkSync_reg)
               begin
                  // a fall right on a clock rise lands either way
                  state_next = ST_ARM;
               end
               else if (csFall)
               begin
                  // clock already low or falling with select
                  state_next     = ST_CONV;
                  edgeCount_next = EDGE_FIRST;
               end
            end
            ST_ARM:
            begin
               if (linkFall)
               begin
                  state_next     = ST_CONV;
                  edgeCount_next = EDGE_FIRST;
               end
            end
            ST_CONV:
            begin
               if (linkFall)
               begin
                  edgeCount_next = edgeCount_reg + EDGE_W'(1);
                  if (edgeCount_next == EDGE_ACQ)
                  begin
                     state_next = ST_TRACK;
                  end
               end
            end
            ST_TRACK:
            begin
               // stay here until select rises, count parked
               state_next = ST_TRACK;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_reg     <= ST_ACQ;
         edgeCount_reg <= EDGE_NONE;
      end
      else
      begin
         state_reg     <= state_next;
         edgeCount_reg <= edgeCount_next;
      end
   end

   // ==========================================================
   // mode outputs, registered from the next state
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         conversionMode  <= 1'b0;
         acquisitionMode <= 1'b1;
      end
      else
      begin
         conversionMode  <= (state_next == ST_CONV);
         acquisitionMode <= (state_next != ST_CONV);
      end
   end

   // ==========================================================
   // input sample path: the buffer absorbs source words while the
   // hold is frozen, so back-pressure reaches the source in a frame
   assign trackEn = (state_reg == ST_ACQ && !csFall)
                 || (state_reg == ST_TRACK);

   adcr_pair_buf #(
      .WIDTH (IN_W),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .clk      (ref_clk),
      .reset    (reset),
      .inData   (diffIn),
      .inValid  (diffValid),
      .inReady  (bufReadyInt),
      .outData  (bufData),
      .outValid (bufValid),
      .outReady (trackEn)
   );

   assign diffReady = bufReadyInt;

   // saturate the differential code to the result range
   function automatic logic [RESULT_W-1:0] clampCode
   (
      input logic signed [IN_W-1:0] v
   );
      logic [RESULT_W-1:0] r;
      r = v[RESULT_W-1:0];
      if (v > POS_EXT)
      begin
         r = POS_FS;
      end
      else if (v < NEG_EXT)
      begin
         r = NEG_FS;
      end
      return r;
   endfunction

   // hold follows the input while tracking, frozen from select fall
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sample_reg <= SAMPLE_RESET;
      end
      else if (trackEn && bufValid)
      begin
         sample_reg <= clampCode($signed(bufData));
      end
   end

   // one-cycle marker of the sampling instant
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sampleStrobe <= 1'b0;
      end
      else
      begin
         sampleStrobe <= csFall;
      end
   end

   // ==========================================================
   // serial output: pin released until edge two, then zero and
   // the result msb first, one bit per falling clock edge
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         serialDataOut <= 1'b0;
         serialDataOe  <= 1'b0;
         shift_reg     <= SAMPLE_RESET;
      end
      else if (csSync_reg)
      begin
         serialDataOut <= 1'b0;
         serialDataOe  <= 1'b0;
      end
      else if (state_reg == ST_CONV && linkFall)
      begin
         if (edgeCount_next == EDGE_ZERO_BIT)
         begin
            serialDataOut <= 1'b0;
            serialDataOe  <= 1'b1;
            shift_reg     <= sample_reg;
         end
         else if (edgeCount_next >= EDGE_MSB)
         begin
            serialDataOut <= shift_reg[RESULT_W-1];
            shift_reg     <= {shift_reg[RESULT_W-2:0], 1'b0};
         end
      end
   end

   // ==========================================================
   // checks
   property p_release_on_rise;
      @(posedge ref_clk) disable iff (reset)
      csRise |=> !serialDataOe && !conversionMode;
   endproperty
   a_release_on_rise: assert property (p_release_on_rise)
      else $error("data pin or conversion kept after select rise");

   property p_hiz_first_period;
      @(posedge ref_clk) disable iff (reset)
      (edgeCount_reg <= EDGE_FIRST) |-> !serialDataOe;
   endproperty
   a_hiz_first_period: assert property (p_hiz_first_period)
      else $error("data pin driven before second falling edge");

   property p_drive_rest;
      @(posedge ref_clk) disable iff (reset)
      (!csSync_reg && edgeCount_reg >= EDGE_ZERO_BIT) |-> serialDataOe;
   endproperty
   a_drive_rest: assert property (p_drive_rest)
      else $error("data pin released inside frame");

   property p_zero_bit;
      @(posedge ref_clk) disable iff (reset)
      (edgeCount_reg == EDGE_ZERO_BIT && !csSync_reg)
         |-> serialDataOut == 1'b0;
   endproperty
   a_zero_bit: assert property (p_zero_bit)
      else $error("leading bit is not zero");

   property p_msb_third;
      @(posedge ref_clk) disable iff (reset)
      (edgeCount_reg == EDGE_MSB && $past(edgeCount_reg) == EDGE_ZERO_BIT)
         |-> serialDataOut == sample_reg[RESULT_W-1];
   endproperty
   a_msb_third: assert property (p_msb_third)
      else $error("msb not on third falling edge");

   property p_acq_at_18;
      @(posedge ref_clk) disable iff (reset)
      (state_reg == ST_CONV && linkFall && edgeCount_reg == EDGE_ACQ - 5'h01
         && !csSync_reg) |=> (acquisitionMode && !conversionMode);
   endproperty
   a_acq_at_18: assert property (p_acq_at_18)
      else $error("acquisition not entered at edge 18");

   property p_clock_low_start;
      @(posedge ref_clk) disable iff (reset)
      (csFall && !clkSync_reg) |=> edgeCount_reg == EDGE_FIRST ##1
         conversionMode;
   endproperty
   a_clock_low_start: assert property (p_clock_low_start)
      else $error("select fall with clock low did not count as edge one");

   property p_clock_high_wait;
      @(posedge ref_clk) disable iff (reset)
      (csFall && clkSync_reg) |=> edgeCount_reg == EDGE_NONE;
   endproperty
   a_clock_high_wait: assert property (p_clock_high_wait)
      else $error("conversion started before next falling edge");

   property p_count_clear;
      @(posedge ref_clk) disable iff (reset)
      csSync_reg |=> edgeCount_reg == EDGE_NONE;
   endproperty
   a_count_clear: assert property (p_count_clear)
      else $error("edge counter not cleared with select high");

   property p_idle_acq;
      @(posedge ref_clk) disable iff (reset)
      csSync_reg [*2] |=> acquisitionMode;
   endproperty
   a_idle_acq: assert property (p_idle_acq)
      else $error("not in acquisition while select high");

   property p_clamp_pos;
      @(posedge ref_clk) disable iff (reset)
      (trackEn && bufValid && $signed(bufData) > POS_EXT)
         |=> sample_reg == POS_FS;
   endproperty
   a_clamp_pos: assert property (p_clamp_pos)
      else $error("positive overrange not clamped");

   property p_hold_frozen;
      @(posedge ref_clk) disable iff (reset)
      (state_reg == ST_CONV) |=> $stable(sample_reg);
   endproperty
   a_hold_frozen: assert property (p_hold_frozen)
      else $error("held sample moved during conversion");

endmodule

// >>> tb/adcr_host_model.sv
// adcr_host_model: behavioural serial controller that frames and reads
`timescale 1ns/1ps
module adcr_host_model
(
   input  wire logic clk,
   output logic      chipSelectN,
   output logic      serialClk,
   input  wire logic dataPin,
   input  wire logic conversionMode
);

   // ==========================================================
   // idle: select high, clock parked low so no edges leak in
   initial
   begin
      chipSelectN = 1'b1;
      serialClk   = 1'b0;
   end

   // ==========================================================
   // mode 0: select falls, clock low; 1: clock high; 2: both fall
   // p[k]/c[k] are sampled just before fall k+1, where data is settled
   task automatic run_frame(input int mode, input int falls,
      output logic [18:1] p, output logic [18:1] c,
      output logic pc, output logic ep);
      @(posedge clk);
      pc = 1'b0;
      if (mode != 0)
      begin
         serialClk <= 1'b1;
         repeat (4) @(posedge clk);
      end
      chipSelectN <= 1'b0; // one select fall per sample
      if (mode == 2)
         serialClk <= 1'b0;
      if (mode == 1)
      begin
         repeat (3) @(posedge clk);
         @(negedge clk);
         pc = conversionMode;
         @(posedge clk);
         serialClk <= 1'b0;
      end
      // select fall always sits four cycles off a rising edge
      for (int k = 1; k <= falls; k++)
      begin
         repeat (4) @(posedge clk);
         serialClk <= 1'b1;
         repeat (3) @(posedge clk);
         @(negedge clk);
         p[k] = dataPin;
         c[k] = conversionMode;
         @(posedge clk);
         if (k < falls)
            serialClk <= 1'b0;
      end
      chipSelectN <= 1'b1;
      repeat (4) @(posedge clk);
      serialClk <= 1'b0;
      @(negedge clk);
      ep = dataPin;
   endtask

endmodule

// >>> tb/adc_serial_readout_frame_tb.sv
// adc_serial_readout_frame_tb: self-checking bench for the readout block
`timescale 1ns/1ps
module adc_serial_readout_frame_tb
   import adcr_pkg::*;
;
   logic        ref_clk;
   logic        reset;
   logic [17:0] diffIn;
   logic        diffValid;
   wire logic   chipSelectN;
   wire logic   serialClk;
   wire logic   dataPin;
   logic        serialDataOut;
   logic        serialDataOe;
   logic        diffReady;
   logic        conversionMode;
   logic        acquisitionMode;
   logic        sampleStrobe;
   int          failCount;
   int          testsRun;
   int          strobes;

   // ==========================================================
   // clock, pin resolution and strobe tally
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // released pin floats: no pull on the data line
   assign dataPin = serialDataOe ? serialDataOut : 1'bz;

   always @(posedge ref_clk)
      if (sampleStrobe === 1'b1)
         strobes <= strobes + 1;

   adcr_readout #(.IN_W(18), .BUF_DEPTH(2)) dut
   (
      .ref_clk         (ref_clk),
      .reset           (reset),
      .chipSelectN     (chipSelectN),
      .serialClk       (serialClk),
      .serialDataOut   (serialDataOut),
      .serialDataOe    (serialDataOe),
      .diffIn          (diffIn),
      .diffValid       (diffValid),
      .diffReady       (diffReady),
      .conversionMode  (conversionMode),
      .acquisitionMode (acquisitionMode),
      .sampleStrobe    (sampleStrobe)
   );

   adcr_host_model host
   (
      .clk            (ref_clk),
      .chipSelectN    (chipSelectN),
      .serialClk      (serialClk),
      .dataPin        (dataPin),
      .conversionMode (conversionMode)
   );

   // ==========================================================
   // shared helpers
   task automatic finishTest();
      $display("Checks run %0d, mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         failCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // expected code worked out independently of the design
   function automatic logic [15:0] clampCode(input logic [17:0] v);
      if ($signed(v) > $signed(18'h07FFF))
         return POS_FS;
      if ($signed(v) < $signed(18'h38000))
         return NEG_FS;
      return v[15:0];
   endfunction

   // wait for ready then release valid; ready is a flop, so negedge is safe
   task automatic take_word();
      int n;
      for (n = 0; n < 400; n++)
      begin
         @(negedge ref_clk);
         if (diffReady === 1'b1)
            break;
      end
      if (n == 400)
      begin
         failCount++;
         finishTest();
      end
      @(posedge ref_clk);
      diffValid <= 1'b0;
   endtask

   task automatic send_word(input logic [17:0] v);
      @(posedge ref_clk);
      diffIn    <= v;
      diffValid <= 1'b1;
      take_word();
   endtask

   task automatic judge(input int mode, input logic [17:0] v, input int s0,
      input logic [18:1] p, input logic [18:1] c, input logic pc,
      input logic ep);
      logic [15:0] got;
      for (int k = 3; k <= 18; k++)
         got[18-k] = p[k];
      check(p[1], 1'bz);
      check(p[2], 1'b0);
      check(got, clampCode(v));
      check(c, 18'h1FFFF);
      check(acquisitionMode, 1'b1);
      check(ep, 1'bz);
      check(18'(strobes - s0), 18'h00001);
      if (mode == 1)
         check(pc, 1'b0);
   endtask

   // ==========================================================
   // scenarios
   task automatic scen_frame(input int mode, input logic [17:0] v);
      logic [18:1] p;
      logic [18:1] c;
      logic        pc;
      logic        ep;
      int          s0;
      send_word(v);
      repeat (4) @(posedge ref_clk);
      s0 = strobes;
      host.run_frame(mode, 18, p, c, pc, ep);
      judge(mode, v, s0, p, c, pc, ep);
   endtask

   // short cycle after ten falls, then a full frame must still line up
   task automatic scen_abort();
      logic [18:1] p;
      logic [18:1] c;
      logic        pc;
      logic        ep;
      send_word(18'h0A5C3);
      repeat (4) @(posedge ref_clk);
      host.run_frame(0, 10, p, c, pc, ep);
      for (int k = 3; k <= 10; k++)
         check(p[k], clampCode(18'h0A5C3) >> (18 - k) & 16'h0001);
      check(ep, 1'bz);
      check(conversionMode, 1'b0);
      scen_frame(0, 18'h00001);
   endtask

   // words arriving mid-conversion queue up; hold stays frozen
   task automatic scen_stall();
      logic [18:1] p;
      logic [18:1] c;
      logic        pc;
      logic        ep;
      int          s0;
      int          n;
      int          hi;
      send_word(18'h01234);
      repeat (4) @(posedge ref_clk);
      s0 = strobes;
      fork
         host.run_frame(0, 18, p, c, pc, ep);
         begin
            for (n = 0; n < 20 && conversionMode !== 1'b1; n++)
               @(negedge ref_clk);
            check(conversionMode, 1'b1);
            send_word(18'h3FFFF);
            send_word(18'h00055);
            @(posedge ref_clk);
            diffIn    <= 18'h2ABCD;
            diffValid <= 1'b1;
            hi = 0;
            repeat (20)
            begin
               @(negedge ref_clk);
               if (diffReady !== 1'b0)
                  hi++;
            end
            check(18'(hi), 18'h00000);
            take_word();
         end
      join
      judge(0, 18'h01234, s0, p, c, pc, ep);
      repeat (6) @(posedge ref_clk);
      s0 = strobes;
      host.run_frame(2, 18, p, c, pc, ep);
      judge(2, 18'h2ABCD, s0, p, c, pc, ep);
   endtask

   // ==========================================================
   // main sequence
   logic [17:0] vals [8] = '{18'h1FFFF, 18'h20000, 18'h07FFF, 18'h38000,
                             18'h08000, 18'h37FFF, 18'h0A5C3, 18'h3FFFF};

   initial
   begin
      reset     = 1'b1;
      diffIn    = 18'h00000;
      diffValid = 1'b0;
      failCount = 0;
      testsRun  = 0;
      strobes   = 0;
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (5) @(posedge ref_clk);
      check(acquisitionMode, 1'b1);
      for (int i = 0; i < 8; i++)
         scen_frame(i % 3, vals[i]);
      scen_abort();
      scen_stall();
      finishTest();
   end

endmodule
